// File: verification/serial_link_tx_control_bench.sv
// bench joining controller and device, driven over the register bus
`timescale 1ns/100ps
module serial_link_tx_control_bench;
    import sltc_pkg::*;
    logic              clock = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, ts = 0, cal = 0, sr = 0;
    logic [7:0]        aa = 0, ra = 0;
    logic [31:0]       wd = 0, rdat, r;
    logic [ADC_W-1:0]  adc = 0;
    logic              awr, wry, bv, arr, rv, lr, spd, lce, u64, tre, mb, ce;
    logic [1:0]        br, rr, ila;
    logic [LINK_N-1:0] ls;
    logic [MODE_W-1:0] am;
    logic [K_W-1:0]    fc;
    logic [9:0]        ofs [4] = '{OFS_MARKER, OFS_ENABLE, OFS_MODE, OFS_KM1};
    logic [7:0]        rstv [4] = '{8'h00, 8'h01, 8'h00, 8'h1f};
    int                n_mismatch = 0, samples_checked = 0;
    always #10 clock = ~clock;
    sltc_if sltc_if_i();
    sltc_host sltc_host_i(.clock(clock), .rst(rst), .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wry), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .regs(sltc_if_i.host),
        .cal_enable(ce), .timestamp_input_receiver_enable(tre));
    sltc_device sltc_device_i(.clock(clock), .rst(rst), .regs(sltc_if_i.device), .adc_sample(adc),
        .timestamp_pin(ts), .sysref_pin(sr), .link_sample(ls), .ila_control_bits(ila), .link_block_reset(lr),
        .serializer_power_down(spd), .link_clock_enable(lce), .active_mode(am), .link_uses_64b66b(u64),
        .frame_count(fc), .multiframe_boundary(mb));
    sltc_properties sltc_properties_i(.clock(clock), .rst(rst), .reg_wr(sltc_if_i.reg_wr),
        .reg_rd(sltc_if_i.reg_rd), .reg_addr(sltc_if_i.reg_addr), .reg_wdata(sltc_if_i.reg_wdata),
        .reg_rdata(sltc_if_i.reg_rdata), .reg_ack(sltc_if_i.reg_ack));
    // one bus transfer; ready is looked at mid-cycle so the edge never races
    task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] d);
        logic pa, pw, ta, tw;
        @(posedge clock);
        pa = 1;
        pw = w;
        aa <= a; ra <= a; wd <= d; awv <= w; wv <= w; arv <= !w; bry <= w; rry <= !w;
        while (pa || pw) begin
            @(negedge clock);
            ta = pa && (w ? awr : arr);
            tw = pw && wry;
            @(posedge clock);
            if (ta) begin
                awv <= 0; arv <= 0; pa = 0;
            end
            if (tw) begin
                wv <= 0; pw = 0;
            end
        end
        do @(negedge clock); while ((w ? bv : rv) !== 1'b1);
        r = w ? 32'(br) : rdat;
        @(posedge clock);
        bry <= 0; rry <= 0;
    endtask : axi
    // device access through the controller; leaves status or read data in r
    task automatic dev(input bit w, input logic [9:0] a, input logic [7:0] d);
        axi(1, HOFS_ADDR, 32'(a));
        axi(1, HOFS_WDATA, 32'(d));
        axi(1, HOFS_CTRL, {23'h0, cal, 6'h0, !w, w});
        do axi(0, HOFS_STATUS, 0); while (r[ST_BUSY] !== 1'b0);
        if (!w) axi(0, HOFS_RDATA, 0);
    endtask : dev
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #200000;
        n_mismatch++;
        end_of_test;
    end
    initial begin
        repeat (8) @(posedge clock);
        rst <= 0;
        foreach (ofs[i]) begin
            dev(0, ofs[i], 0);
            chk(r, rstv[i]);
        end
        chk(lce, 1);
        dev(1, OFS_ENABLE, 8'h00);
        sr <= 1;
        repeat (6) @(posedge clock);
        chk({lr, spd, lce, ls}, {3'b110, 16'h0});
        chk({fc, mb}, 0);
        dev(1, OFS_MODE, 8'he1);
        dev(0, OFS_MODE, 0);
        chk(r, 8'h21);
        chk({am, u64}, 7'h43);
        dev(1, OFS_KM1, 8'h0f);
        dev(0, OFS_KM1, 0);
        chk(r, 8'h0f);
        dev(1, OFS_KM1, 8'h02);
        chk(r[ST_REFUSED], 1);
        dev(1, OFS_MARKER, 8'h01);
        chk(tre, 1);
        cal = 1;
        axi(1, HOFS_CTRL, 32'h100);
        dev(1, OFS_ENABLE, 8'h01);
        chk(r[ST_REFUSED], 0);
        dev(1, OFS_MODE, 8'h00);
        chk(r[ST_REFUSED], 1);
        dev(1, OFS_KM1, 8'h1f);
        chk(r[ST_REFUSED], 1);
        dev(1, OFS_MARKER, 8'h00);
        chk(r[ST_REFUSED], 1);
        adc <= 9'h1ff;
        ts <= 1;
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk(ls, 0);
        @(negedge clock);
        chk(ls, 16'hff81);
        chk(ls[7], 1);
        chk(ila, 0);
        dev(1, OFS_ENABLE, 8'h00);
        dev(1, OFS_MARKER, 8'h00);
        dev(1, OFS_ENABLE, 8'h01);
        repeat (5) @(posedge clock);
        chk(ls, 16'hff80);
        // mode 0x21: k = 256/2 frames whatever km1 holds
        do @(negedge clock); while (mb !== 1'b1);
        repeat (127) @(negedge clock);
        chk({mb, fc}, 10'h07f);
        @(negedge clock);
        chk({mb, fc}, 10'h200);
        axi(1, HOFS_CTRL, 0);
        axi(0, HOFS_STATUS, 0);
        chk(r[ST_LINK_EN:ST_BUSY], 3'b110);
        chk(ce, 1);
        axi(1, 8'h40, 0);
        chk(r, 2);
        axi(0, 8'h40, 0);
        chk(rr, 2);
        end_of_test;
    end
endmodule : serial_link_tx_control_bench

// File: verification/sltc_properties.sv
// register port assertions between controller and device
`timescale 1ns/100ps
module sltc_properties
    import sltc_pkg::*;
(
    input wire logic              clock,
    input wire logic              rst,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              reg_ack
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // one-bit registers must never show stored reserved bits
    sequence flag_read_s;
        reg_rd && (reg_addr == OFS_MARKER || reg_addr == OFS_ENABLE);
    endsequence
    ack_timing_a: assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("ack missing");
    ack_cause_a: assert property (reg_ack |-> $past(reg_wr || reg_rd)) else $error("stray ack");
    rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata)) else $error("read data moved");
    flag_read_a: assert property (flag_read_s |=> reg_rdata[7:1] == 7'h00) else $error("flag read");
    km1_legal_a: assert property (reg_wr && reg_addr == OFS_KM1 |-> reg_wdata >= KM1_MIN_LEGAL) else $error("km1");
    reserved_zero_a: assert property (reg_wr && reg_addr == OFS_MODE |-> reg_wdata[7:6] == 2'h0)
        else $error("reserved bits written");
endmodule : sltc_properties

// File: verilog/sltc_device.sv
// device end: link control registers, sample marker insertion and multiframe counter
//
// Function
// - timestamp bit replaces field bit 0, below the sample lsb, when enabled
// - marker at lsb of full link field
// - alignment sequence advertises zero control bits
// - timestamp latency equals converter sample latency
// - software also enables timestamp input receiver
// - enable bit switches link on, resets to one
// - disabled: link reset, serializers off, clocks gated
// - disabled: multiframe counter held, sysref ignored
// - software disables link before other config changes
// - calibration on before link, off after
// - six-bit mode field selects link configuration
// - mode changes only with link, calibration off
// - frames per multiframe less one, reset 31
// - software programs only mode-legal frame counts
// - 64b66b modes use 256 times e over f
// - frame count changes only while link disabled
// - software writes reserved bits as zero
`timescale 1ns/100ps
module sltc_device
    import sltc_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst,
    sltc_if.device                 regs,
    input  wire logic [ADC_W-1:0]  adc_sample,
    input  wire logic              timestamp_pin,
    input  wire logic              sysref_pin,
    output logic      [LINK_N-1:0] link_sample,
    output logic      [1:0]        ila_control_bits,
    output logic                   link_block_reset,
    output logic                   serializer_power_down,
    output logic                   link_clock_enable,
    output logic      [MODE_W-1:0] active_mode,
    output logic                   link_uses_64b66b,
    output logic      [K_W-1:0]    frame_count,
    output logic                   multiframe_boundary
);

    // ********************************
    // helpers
    // ********************************

    // modes at or above the first 64b66b code use that link layer
    function automatic logic is_64b66b(input logic [MODE_W-1:0] m);
        return m >= MODE_64B_FIRST;
    endfunction : is_64b66b

    // e is one block, f is 2**m[1:0] octets, so k = 256*e/f
    function automatic logic [K_W-1:0] k_64b_less_one(input logic [MODE_W-1:0] m);
        return (K_64B_BASE >> m[1:0]) - 9'h001;
    endfunction : k_64b_less_one

    // converter sample is left-justified in the n-bit field; bit 0 is the marker slot
    function automatic logic [LINK_N-1:0] build_sample(input logic [ADC_W-1:0] s,
                                                       input logic             ts,
                                                       input logic             ins);
        logic [LINK_N-1:0] f;
        f = {s, {(LINK_N-ADC_W){1'b0}}};
        if (ins) begin
            f[0] = ts;
        end
        return f;
    endfunction : build_sample

    // ********************************
    // register file
    // ********************************
    logic [DATA_W-1:0] marker_r;
    logic [DATA_W-1:0] enable_r;
    logic [DATA_W-1:0] mode_r;
    logic [DATA_W-1:0] km1_r;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic              ack_r;
    logic [DATA_W-1:0] wval;

    // reserved bits are masked off so they always read back as zero
    assign wval = regs.reg_wdata & field_mask(regs.reg_addr);

    // register writes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            marker_r <= RST_MARKER;
            enable_r <= RST_ENABLE;
            mode_r   <= RST_MODE;
            km1_r    <= RST_KM1;
        end else if (regs.reg_wr) begin
            if (regs.reg_addr == OFS_MARKER) begin
                marker_r <= wval;
            end else if (regs.reg_addr == OFS_ENABLE) begin
                enable_r <= wval;
            end else if (regs.reg_addr == OFS_MODE) begin
                mode_r <= wval;
            end else if (regs.reg_addr == OFS_KM1) begin
                km1_r <= wval;
            end
        end
    end

    // read decode; unmapped addresses read as zero
    always_comb begin
        if (regs.reg_addr == OFS_MARKER) begin
            rdata_nxt = marker_r;
        end else if (regs.reg_addr == OFS_ENABLE) begin
            rdata_nxt = enable_r;
        end else if (regs.reg_addr == OFS_MODE) begin
            rdata_nxt = mode_r;
        end else if (regs.reg_addr == OFS_KM1) begin
            rdata_nxt = km1_r;
        end else begin
            rdata_nxt = ZERO8;
        end
    end

    // answer one cycle after either strobe; read data held until the next read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_r   <= 1'b0;
            rdata_r <= ZERO8;
        end else begin
            ack_r <= regs.reg_wr | regs.reg_rd;
            if (regs.reg_rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign regs.reg_ack   = ack_r;
    assign regs.reg_rdata = rdata_r;

    // ********************************
    // enable effects
    // ********************************
    logic link_on;
    logic insert_on;

    assign link_on               = enable_r[BIT_EN];
    assign insert_on             = marker_r[BIT_TS];
    assign link_block_reset      = ~link_on;
    assign serializer_power_down = ~link_on;
    assign link_clock_enable     = link_on;
    assign active_mode           = mode_r[MODE_W-1:0];
    assign link_uses_64b66b      = is_64b66b(mode_r[MODE_W-1:0]);
    // the marker is a payload trick only, never announced to the receiver
    assign ila_control_bits      = ILA_CS;

    // ********************************
    // pin synchronisers
    // ********************************
    logic ts_meta_r;
    logic ts_sync_r;
    logic sr_meta_r;
    logic sr_sync_r;
    logic sr_prev_r;

    // two stages each; timestamp uses the second stage, sysref compares it with a third flop for the edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ts_meta_r <= 1'b0;
            ts_sync_r <= 1'b0;
            sr_meta_r <= 1'b0;
            sr_sync_r <= 1'b0;
            sr_prev_r <= 1'b0;
        end else begin
            ts_meta_r <= timestamp_pin;
            ts_sync_r <= ts_meta_r;
            sr_meta_r <= sysref_pin;
            sr_sync_r <= sr_meta_r;
            sr_prev_r <= sr_sync_r;
        end
    end

    // ********************************
    // sample path
    // ********************************
    logic [ADC_W-1:0]  adc_pipe_r [PIPE_DEPTH];
    logic [LINK_N-1:0] sample_r;

    // the converter sample is delayed by the synchroniser depth so a mark
    // lands on the sample taken at the same instant as the pin edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < PIPE_DEPTH; i++) begin
                adc_pipe_r[i] <= '0;
            end
        end else begin
            adc_pipe_r[0] <= adc_sample;
            for (int i = 1; i < PIPE_DEPTH; i++) begin
                adc_pipe_r[i] <= adc_pipe_r[i-1];
            end
        end
    end

    // output field; cleared while the link block sits in reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sample_r <= '0;
        end else if (!link_on) begin
            sample_r <= '0;
        end else begin
            sample_r <= build_sample(adc_pipe_r[PIPE_DEPTH-1], ts_sync_r, insert_on);
        end
    end

    assign link_sample = sample_r;

    // ********************************
    // multiframe counter
    // ********************************
    logic [K_W-1:0] k_less_one;
    logic [K_W-1:0] count_r;
    logic           boundary_r;
    logic           sysref_edge;

    // 64b66b ignores the programmed count entirely
    assign k_less_one  = is_64b66b(mode_r[MODE_W-1:0]) ? k_64b_less_one(mode_r[MODE_W-1:0])
                                                       : {1'b0, km1_r};
    assign sysref_edge = sr_sync_r & ~sr_prev_r;

    // one frame per clock; sysref realigns only while the link runs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_r    <= '0;
            boundary_r <= 1'b0;
        end else if (!link_on) begin
            count_r    <= '0;
            boundary_r <= 1'b0;
        end else if (sysref_edge || count_r >= k_less_one) begin
            count_r    <= '0;
            boundary_r <= 1'b1;
        end else begin
            count_r    <= count_r + 9'h001;
            boundary_r <= 1'b0;
        end
    end

    assign frame_count         = count_r;
    assign multiframe_boundary = boundary_r;

endmodule : sltc_device

// File: verilog/sltc_host.sv
// controller end: axi4-lite slave that issues checked register accesses to the device
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
module sltc_host
    import sltc_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    sltc_if.host                   regs,
    output logic                   cal_enable,
    output logic                   timestamp_input_receiver_enable
);

    typedef enum {SLTC_IDLE, SLTC_WAIT} sltc_state_type;

    // ********************************
    // axi write channel capture
    // ********************************
    logic              aw_hold_r;
    logic              w_hold_r;
    logic [AXI_AW-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              do_write;

    assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
    assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
    assign do_write      = aw_hold_r & w_hold_r & ~bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    // address and data may arrive in either order; the response follows both
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
            end
            if (do_write) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= (awaddr_r == HOFS_ADDR || awaddr_r == HOFS_WDATA ||
                              awaddr_r == HOFS_CTRL) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ********************************
    // command registers and device sequencer
    // ********************************
    sltc_state_type    state_r;
    logic [ADDR_W-1:0] cmd_addr_r;
    logic [DATA_W-1:0] cmd_wdata_r;
    logic [DATA_W-1:0] dev_rdata_r;
    logic              cal_r;
    logic              refused_r;
    logic              shadow_en_r;
    logic              shadow_ts_r;
    logic              wr_r;
    logic              rd_r;
    logic [DATA_W-1:0] safe_wdata;
    logic              refuse_wr;
    logic              go_wr;
    logic              go_rd;
    logic              cal_clear_bad;

    // reserved bits forced to zero on the way out
    assign safe_wdata = cmd_wdata_r & field_mask(cmd_addr_r);

    // configuration changes only while the link is off; enable needs calibration first
    always_comb begin
        refuse_wr = 1'b0;
        if (cmd_addr_r == OFS_ENABLE) begin
            refuse_wr = safe_wdata[BIT_EN] & ~cal_r;
        end else if (cmd_addr_r == OFS_MODE) begin
            refuse_wr = shadow_en_r | cal_r;
        end else if (cmd_addr_r == OFS_KM1) begin
            refuse_wr = shadow_en_r | (safe_wdata < KM1_MIN_LEGAL);
        end else if (cmd_addr_r == OFS_MARKER) begin
            refuse_wr = shadow_en_r;
        end
    end

    assign go_wr         = do_write && awaddr_r == HOFS_CTRL && wdata_r[CTRL_WRITE] && state_r == SLTC_IDLE;
    assign go_rd         = do_write && awaddr_r == HOFS_CTRL && wdata_r[CTRL_READ] && state_r == SLTC_IDLE
                           && !wdata_r[CTRL_WRITE];
    // calibration may not drop while the link still runs
    assign cal_clear_bad = do_write && awaddr_r == HOFS_CTRL && !wdata_r[CTRL_CAL] && shadow_en_r && cal_r;

    // software-visible command fields
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cmd_addr_r  <= '0;
            cmd_wdata_r <= ZERO8;
            cal_r       <= 1'b0;
        end else if (do_write) begin
            if (awaddr_r == HOFS_ADDR && s_axi_wstrb != 4'h0) begin
                cmd_addr_r <= wdata_r[ADDR_W-1:0];
            end else if (awaddr_r == HOFS_WDATA) begin
                cmd_wdata_r <= wdata_r[DATA_W-1:0];
            end else if (awaddr_r == HOFS_CTRL && !cal_clear_bad) begin
                cal_r <= wdata_r[CTRL_CAL];
            end
        end
    end

    // sequencer: one strobe, then wait for the device's answer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r     <= SLTC_IDLE;
            wr_r        <= 1'b0;
            rd_r        <= 1'b0;
            refused_r   <= 1'b0;
            dev_rdata_r <= ZERO8;
            shadow_en_r <= RST_ENABLE[BIT_EN];
            shadow_ts_r <= RST_MARKER[BIT_TS];
        end else begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            case (state_r)
                SLTC_IDLE: begin
                    if (go_wr) begin
                        refused_r <= refuse_wr | cal_clear_bad;
                        if (!refuse_wr) begin
                            wr_r    <= 1'b1;
                            state_r <= SLTC_WAIT;
                            if (cmd_addr_r == OFS_ENABLE) begin
                                shadow_en_r <= safe_wdata[BIT_EN];
                            end else if (cmd_addr_r == OFS_MARKER) begin
                                shadow_ts_r <= safe_wdata[BIT_TS];
                            end
                        end
                    end else if (go_rd) begin
                        refused_r <= cal_clear_bad;
                        rd_r      <= 1'b1;
                        state_r   <= SLTC_WAIT;
                    end else if (cal_clear_bad) begin
                        refused_r <= 1'b1;
                    end
                end
                SLTC_WAIT: begin
                    if (regs.reg_ack) begin
                        dev_rdata_r <= regs.reg_rdata;
                        state_r     <= SLTC_IDLE;
                    end
                end
                default: state_r <= SLTC_IDLE;
            endcase
        end
    end

    assign regs.reg_wr                     = wr_r;
    assign regs.reg_rd                     = rd_r;
    assign regs.reg_addr                   = cmd_addr_r;
    assign regs.reg_wdata                  = safe_wdata;
    assign cal_enable                      = cal_r;
    // marker insertion is useless without the pin receiver, so they follow together
    assign timestamp_input_receiver_enable = shadow_ts_r;

    // ********************************
    // axi read channel
    // ********************************
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // answer one cycle after the address is taken
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r  <= RESP_OKAY;
            if (s_axi_araddr == HOFS_ADDR) begin
                rdata_r <= {22'h00_0000, cmd_addr_r};
            end else if (s_axi_araddr == HOFS_WDATA) begin
                rdata_r <= {24'h00_0000, cmd_wdata_r};
            end else if (s_axi_araddr == HOFS_CTRL) begin
                rdata_r <= {23'h00_0000, cal_r, 8'h00};
            end else if (s_axi_araddr == HOFS_STATUS) begin
                rdata_r <= {29'h0000_0000, shadow_en_r, refused_r, state_r != SLTC_IDLE};
            end else if (s_axi_araddr == HOFS_RDATA) begin
                rdata_r <= {24'h00_0000, dev_rdata_r};
            end else begin
                rdata_r <= '0;
                rresp_r <= RESP_SLVERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule : sltc_host

// File: verilog/sltc_if.sv
// register port between the link controller and the device
`timescale 1ns/100ps
interface sltc_if;
    import sltc_pkg::*;
    logic              reg_wr;    // one-cycle write strobe
    logic              reg_rd;    // one-cycle read strobe
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic              reg_ack;   // one-cycle answer

    modport device (input reg_wr, reg_rd, reg_addr, reg_wdata, output reg_rdata, reg_ack);
    modport host (output reg_wr, reg_rd, reg_addr, reg_wdata, input reg_rdata, reg_ack);
endinterface : sltc_if

// File: verilog/sltc_pkg.sv
// shared constants, register map and helpers for the serial link tx control block
package sltc_pkg;
    // ********************************
    // widths
    // ********************************
    localparam int unsigned ADDR_W     = 10;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned ADC_W      = 9;
    localparam int unsigned LINK_N     = 16;
    localparam int unsigned K_W        = 9;
    localparam int unsigned MODE_W     = 6;
    localparam int unsigned PIPE_DEPTH = 2;
    localparam int unsigned AXI_AW     = 8;

    // ********************************
    // device register map
    // ********************************
    localparam logic [ADDR_W-1:0] OFS_MARKER = 10'h160;
    localparam logic [ADDR_W-1:0] OFS_ENABLE = 10'h200;
    localparam logic [ADDR_W-1:0] OFS_MODE   = 10'h201;
    localparam logic [ADDR_W-1:0] OFS_KM1    = 10'h202;
    localparam logic [DATA_W-1:0] RST_MARKER = 8'h00;
    localparam logic [DATA_W-1:0] RST_ENABLE = 8'h01;
    localparam logic [DATA_W-1:0] RST_MODE   = 8'h00;
    localparam logic [DATA_W-1:0] RST_KM1    = 8'h1f;
    localparam logic [DATA_W-1:0] MASK_ONE   = 8'h01;
    localparam logic [DATA_W-1:0] MASK_MODE  = 8'h3f;
    localparam logic [DATA_W-1:0] MASK_KM1   = 8'hff;
    localparam logic [DATA_W-1:0] ZERO8      = 8'h00;
    localparam int unsigned       BIT_TS     = 0;
    localparam int unsigned       BIT_EN     = 0;

    // ********************************
    // link parameters
    // ********************************
    localparam logic [1:0]        ILA_CS          = 2'h0;
    localparam logic [K_W-1:0]    K_64B_BASE      = 9'h100;
    localparam logic [MODE_W-1:0] MODE_64B_FIRST  = 6'h20;
    localparam logic [DATA_W-1:0] KM1_MIN_LEGAL   = 8'h03;

    // ********************************
    // controller register map (axi4-lite)
    // ********************************
    localparam logic [AXI_AW-1:0] HOFS_ADDR   = 8'h00;
    localparam logic [AXI_AW-1:0] HOFS_WDATA  = 8'h04;
    localparam logic [AXI_AW-1:0] HOFS_CTRL   = 8'h08;
    localparam logic [AXI_AW-1:0] HOFS_STATUS = 8'h0c;
    localparam logic [AXI_AW-1:0] HOFS_RDATA  = 8'h10;
    localparam int unsigned       CTRL_WRITE  = 0;
    localparam int unsigned       CTRL_READ   = 1;
    localparam int unsigned       CTRL_CAL    = 8;
    localparam int unsigned       ST_BUSY     = 0;
    localparam int unsigned       ST_REFUSED  = 1;
    localparam int unsigned       ST_LINK_EN  = 2;
    localparam logic [1:0]        RESP_OKAY   = 2'b00;
    localparam logic [1:0]        RESP_SLVERR = 2'b10;

    // writable bits of each device register; reserved bits are never stored
    function automatic logic [DATA_W-1:0] field_mask(input logic [ADDR_W-1:0] a);
        if (a == OFS_MARKER || a == OFS_ENABLE) begin
            return MASK_ONE;
        end else if (a == OFS_MODE) begin
            return MASK_MODE;
        end else if (a == OFS_KM1) begin
            return MASK_KM1;
        end else begin
            return ZERO8;
        end
    endfunction : field_mask
endpackage : sltc_pkg
